// ### logic/emb_pkg.sv
package emb_pkg;

  // machine cycle: 12 oscillator periods, counted 0..11 from cycle start
  localparam int unsigned CYC_LEN = 12;
  localparam logic [3:0] CNT_LAST = 4'hb;
  // address latch strobe high periods 0..1, falls at edge of period 2
  localparam logic [3:0] ALE_RISE = 4'h0;
  localparam logic [3:0] ALE_FALL = 4'h2;
  // low address held one period after the latch strobe falls
  localparam logic [3:0] ADDR_HOLD_END = 4'h3;
  // fetch strobe low periods 3..5 (three periods)
  localparam logic [3:0] FETCH_LOW = 4'h3;
  localparam logic [3:0] FETCH_HIGH = 4'h6;
  // fetched byte captured in the last low period of the fetch strobe
  localparam logic [3:0] FETCH_CAPT = 4'h5;
  // read and write strobes low periods 5..10 (six periods)
  localparam logic [3:0] DSTB_LOW = 4'h5;
  localparam logic [3:0] DSTB_HIGH = 4'hb;
  localparam logic [3:0] READ_CAPT = 4'ha;
  // write data driven one period before the write strobe falls
  localparam logic [3:0] WDATA_ON = 4'h4;
  // port sample and update points inside the machine cycle
  localparam logic [3:0] STATE5_PHASE2 = 4'h9;
  localparam logic [3:0] STATE6_PHASE2 = 4'hb;
  // read bus turnaround: memory may drive two periods after the read strobe
  localparam logic [1:0] TURN_PERIODS = 2'h2;

  typedef enum logic [1:0] {EMB_FETCH, EMB_READ, EMB_WRITE} emb_kind_t;

  typedef struct packed {
    emb_kind_t kind;
    logic [15:0] addr;
    logic [7:0] wdata;
  } emb_req_t;

  typedef struct packed {
    logic ale;
    logic program_fetch_strobe;
    logic rd_n;
    logic wr_n;
    logic [7:0] low_addr_data_port_o;
    logic low_addr_data_port_oe;
    logic [7:0] high_addr_port;
  } emb_pins_t;

endpackage

// ### logic/emb_sync2.sv
`timescale 1ns/10ps
// two-stage synchroniser for a bus of pin inputs
module emb_sync2 #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // first stage read only by the second
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// ### logic/emb_flash_gate.sv
`timescale 1ns/10ps
// flash mode qualifier: strap pins held high, sampled after sync
module emb_flash_gate (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [2:0] strap_sync,
  input wire logic flash_req,
  output logic flash_mode,
  output logic flash_grant
);
  logic mode_q;

  // mode entered only while all three strap pins read high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_q <= 1'b0;
    end else begin
      mode_q <= &strap_sync;
    end
  end

  assign flash_mode = mode_q;
  assign flash_grant = mode_q & flash_req;
endmodule

// ### logic/emb_bus_seq.sv
`timescale 1ns/10ps
// Functional notes
// - address valid a period before latch strobe falls; strobe high two periods.
// - low address byte held one period after latch strobe falls.
// - fetch strobe falls one period after latch strobe, low three periods.
// - fetched byte captured internally before fetch strobe rises.
// - high address and address phase stay stable for the whole cycle.
// - read strobe falls three periods after latch strobe, low six periods.
// - device keeps port released two periods after read strobe rises.
// - write data driven a period before write strobe; strobe low six periods.
// - write data held one period after write strobe rises.
// - ports sampled at state5_phase2, outputs updated end of state6_phase2; code does both only in busy bus cycles.
// - flash access only in flash mode with reset, latch, fetch pins high.
// - clock may stop at either level without loss of state.
module emb_bus_seq (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire emb_pkg::emb_req_t req,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic [7:0] low_addr_data_port_i,
  output emb_pkg::emb_pins_t pins,
  input wire logic [7:0] gp_port_i,
  input wire logic [7:0] gp_out_next,
  output logic [7:0] gp_port_in_q,
  output logic [7:0] gp_port_out,
  output logic cycle_start,
  input wire logic rst_pin,
  input wire logic ale_pin_i,
  input wire logic fetch_pin_i,
  input wire logic flash_req,
  output logic flash_mode,
  output logic flash_grant
);
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY} emb_state_t;

  typedef struct packed {
    emb_state_t st;
    logic [3:0] cnt;
    emb_pkg::emb_req_t cur;
    emb_pkg::emb_pins_t pins;
    logic [1:0] turn;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic [7:0] gp_in;
    logic [7:0] gp_out;
    logic [7:0] gp_stage;
  } emb_state_s_t;

  emb_state_s_t s_q, s_d;
  logic [7:0] bus_sync;
  logic [7:0] gp_sync;
  logic [2:0] strap_sync;
  logic active_fetch, active_read, active_write;

  // pin inputs pass two flip-flops before use
  emb_sync2 #(.W(8)) u_bus_sync (
    .core_clk(core_clk),
    .rst(rst),
    .din(low_addr_data_port_i),
    .dout(bus_sync)
  );
  emb_sync2 #(.W(8)) u_gp_sync (
    .core_clk(core_clk),
    .rst(rst),
    .din(gp_port_i),
    .dout(gp_sync)
  );
  emb_sync2 #(.W(3)) u_strap_sync (
    .core_clk(core_clk),
    .rst(rst),
    .din({rst_pin, ale_pin_i, fetch_pin_i}),
    .dout(strap_sync)
  );

  emb_flash_gate u_flash (
    .core_clk(core_clk),
    .rst(rst),
    .strap_sync(strap_sync),
    .flash_req(flash_req),
    .flash_mode(flash_mode),
    .flash_grant(flash_grant)
  );

  // kind of the running cycle
  always_comb begin
    active_fetch = (s_q.st == ST_BUSY) && (s_q.cur.kind == emb_pkg::EMB_FETCH);
    active_read = (s_q.st == ST_BUSY) && (s_q.cur.kind == emb_pkg::EMB_READ);
    active_write = (s_q.st == ST_BUSY) && (s_q.cur.kind == emb_pkg::EMB_WRITE);
  end

  // a new cycle starts only at the machine cycle boundary, bus not turning
  assign req_ready = (s_q.st == ST_IDLE) && (s_q.turn == 2'h0) && !flash_mode;
  assign cycle_start = req_valid && req_ready;

  // next state: sequencing is purely a period count, so a stopped clock
  // freezes every strobe and register in place
  always_comb begin
    s_d = s_q;
    s_d.rsp_valid = 1'b0;
    if (s_q.turn != 2'h0) begin
      s_d.turn = s_q.turn - 2'h1;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        s_d.cnt = 4'h0;
        if (cycle_start) begin
          s_d.st = ST_BUSY;
          s_d.cur = req;
          // address on the pins with the latch strobe high
          s_d.pins.ale = 1'b1;
          s_d.pins.high_addr_port = req.addr[15:8];
          s_d.pins.low_addr_data_port_o = req.addr[7:0];
          s_d.pins.low_addr_data_port_oe = 1'b1;
        end
      end
      ST_BUSY: begin
        s_d.cnt = s_q.cnt + 4'h1;
        // latch strobe falls after two periods high
        if (s_q.cnt + 4'h1 == emb_pkg::ALE_FALL) begin
          s_d.pins.ale = 1'b0;
        end
        // release low address after its hold period; write keeps driving
        if (s_q.cnt + 4'h1 == emb_pkg::ADDR_HOLD_END) begin
          if (!active_write) begin
            s_d.pins.low_addr_data_port_oe = 1'b0;
          end
        end
        // fetch strobe window
        if (active_fetch && (s_q.cnt + 4'h1 == emb_pkg::FETCH_LOW)) begin
          s_d.pins.program_fetch_strobe = 1'b0;
        end
        if (active_fetch && (s_q.cnt == emb_pkg::FETCH_CAPT)) begin
          s_d.rsp_data = bus_sync;
          s_d.rsp_valid = 1'b1;
        end
        if (active_fetch && (s_q.cnt + 4'h1 == emb_pkg::FETCH_HIGH)) begin
          s_d.pins.program_fetch_strobe = 1'b1;
        end
        // write data one period before the write strobe
        if (active_write && (s_q.cnt + 4'h1 == emb_pkg::WDATA_ON)) begin
          s_d.pins.low_addr_data_port_o = s_q.cur.wdata;
          s_d.pins.low_addr_data_port_oe = 1'b1;
        end
        if (s_q.cnt + 4'h1 == emb_pkg::DSTB_LOW) begin
          if (active_read) begin
            s_d.pins.rd_n = 1'b0;
          end
          if (active_write) begin
            s_d.pins.wr_n = 1'b0;
          end
        end
        if (active_read && (s_q.cnt == emb_pkg::READ_CAPT)) begin
          s_d.rsp_data = bus_sync;
          s_d.rsp_valid = 1'b1;
        end
        if (s_q.cnt + 4'h1 == emb_pkg::DSTB_HIGH) begin
          s_d.pins.rd_n = 1'b1;
          s_d.pins.wr_n = 1'b1;
          if (active_read) begin
            s_d.turn = emb_pkg::TURN_PERIODS;
          end
        end
        // cycle end: write data held through the final period
        if (s_q.cnt == emb_pkg::CNT_LAST) begin
          s_d.st = ST_IDLE;
          s_d.pins.low_addr_data_port_oe = 1'b0;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    // general ports: sample and update points
    if ((s_q.st == ST_BUSY) && (s_q.cnt == emb_pkg::STATE5_PHASE2)) begin
      s_d.gp_in = gp_sync;
      s_d.gp_stage = gp_out_next;
    end
    if ((s_q.st == ST_BUSY) && (s_q.cnt == emb_pkg::STATE6_PHASE2)) begin
      s_d.gp_out = s_q.gp_stage;
    end
  end

  // register the whole state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.cur.kind <= emb_pkg::EMB_FETCH;
      s_q.pins.program_fetch_strobe <= 1'b1;
      s_q.pins.rd_n <= 1'b1;
      s_q.pins.wr_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins = s_q.pins;
  assign rsp_valid = s_q.rsp_valid;
  assign rsp_data = s_q.rsp_data;
  assign gp_port_in_q = s_q.gp_in;
  assign gp_port_out = s_q.gp_out;
endmodule

// ### dv/emb_bus_assertions.sv
`timescale 1ns/10ps
// port-level protocol checker for the bus sequencer
module emb_bus_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_ready,
  input wire emb_pkg::emb_req_t req,
  input wire logic rsp_valid,
  input wire emb_pkg::emb_pins_t pins,
  input wire logic cycle_start,
  input wire logic flash_mode
);
  logic [15:0] addr_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // remember the address of the accepted request
  always_ff @(posedge core_clk) begin
    if (cycle_start) begin
      addr_q <= req.addr;
    end
  end
  sequence ale_pulse_s;
    pins.ale[*2] ##1 !pins.ale;
  endsequence
  sequence addr_out_s;
    (pins.low_addr_data_port_oe && pins.low_addr_data_port_o == addr_q[7:0])[*3];
  endsequence
  ale_pulse_a: assert property (cycle_start |-> ##1 ale_pulse_s)
    else $error("latch strobe pulse wrong");
  addr_phase_a: assert property (cycle_start |-> ##1 addr_out_s)
    else $error("low address not held");
  high_addr_a: assert property (cycle_start |-> ##1 (pins.high_addr_port == addr_q[15:8])[*8])
    else $error("high address moved");
  fetch_strobe_a: assert property (cycle_start && req.kind == emb_pkg::EMB_FETCH |-> ##1
    pins.program_fetch_strobe[*3] ##1 !pins.program_fetch_strobe[*3] ##1 pins.program_fetch_strobe)
    else $error("fetch strobe timing wrong");
  read_strobe_a: assert property (cycle_start && req.kind == emb_pkg::EMB_READ |-> ##1
    pins.rd_n[*5] ##1 !pins.rd_n[*6] ##1 pins.rd_n) else $error("read strobe timing wrong");
  write_strobe_a: assert property (cycle_start && req.kind == emb_pkg::EMB_WRITE |-> ##1
    pins.wr_n[*5] ##1 !pins.wr_n[*6] ##1 pins.wr_n) else $error("write strobe timing wrong");
  write_setup_a: assert property ($fell(pins.wr_n) |-> $past(pins.low_addr_data_port_oe)
    && $stable(pins.low_addr_data_port_o)) else $error("write data late");
  write_hold_a: assert property ($rose(pins.wr_n) |-> pins.low_addr_data_port_oe
    && $stable(pins.low_addr_data_port_o)) else $error("write data dropped early");
  strobe_release_a: assert property ($fell(pins.program_fetch_strobe) || $fell(pins.rd_n)
    |-> !pins.low_addr_data_port_oe) else $error("port driven under strobe");
  read_turn_a: assert property ($rose(pins.rd_n) |-> (!pins.low_addr_data_port_oe)[*2])
    else $error("port driven in turnaround");
  fetch_capt_a: assert property ($rose(pins.program_fetch_strobe) |-> rsp_valid)
    else $error("fetched byte not captured");
  flash_refuse_a: assert property (flash_mode |-> !req_ready)
    else $error("request accepted in flash mode");
endmodule
bind emb_bus_seq emb_bus_assertions u_chk (.core_clk(core_clk), .rst(rst),
  .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .pins(pins),
  .cycle_start(cycle_start), .flash_mode(flash_mode));

// ### dv/emb_mem_model.sv
`timescale 1ns/10ps
// behavioural external program and data memory on the shared port
module emb_mem_model (
  input wire logic core_clk,
  input wire emb_pkg::emb_pins_t pins,
  output logic [7:0] bus
);
  logic [7:0] mem_q [256];
  logic [7:0] lat_q;
  logic [7:0] last_q = 8'h00;
  logic hold_q = 1'b0;
  // latch the low address, store writes, track read hold
  always_ff @(posedge core_clk) begin
    if (pins.ale) lat_q <= pins.low_addr_data_port_o;
    if (!pins.wr_n) mem_q[lat_q] <= pins.low_addr_data_port_o;
    hold_q <= !pins.rd_n;
    last_q <= bus;
  end
  // wire level: device, then memory, else a changing float value
  assign bus = pins.low_addr_data_port_oe ? pins.low_addr_data_port_o :
    !pins.program_fetch_strobe ? ~lat_q :
    (!pins.rd_n || hold_q) ? mem_q[lat_q] : ~last_q;
endmodule

// ### dv/testbench.sv
`timescale 1ns/10ps
// self-checking bench for the external bus sequencer
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  emb_pkg::emb_req_t req = '0;
  logic [7:0] gp_port_i = 8'h3c;
  logic [7:0] gp_out_next = 8'h96;
  logic [2:0] strap = 3'h0;
  logic flash_req = 1'b0;
  logic req_ready, rsp_valid, cycle_start, flash_mode, flash_grant;
  logic [7:0] rsp_data, bus, gp_port_in_q, gp_port_out;
  emb_pkg::emb_pins_t pins;
  int n_errors = 0;
  int comparisons = 0;
  // nominal program pulse of 300 us in 25 ns periods
  localparam int PULSE_CYCLES = 12000;
  always #12.5 core_clk = ~core_clk;
  emb_bus_seq DUT (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .low_addr_data_port_i(bus), .pins(pins), .gp_port_i(gp_port_i),
    .gp_out_next(gp_out_next), .gp_port_in_q(gp_port_in_q), .gp_port_out(gp_port_out),
    .cycle_start(cycle_start), .rst_pin(strap[0]), .ale_pin_i(strap[1]),
    .fetch_pin_i(strap[2]), .flash_req(flash_req), .flash_mode(flash_mode),
    .flash_grant(flash_grant));
  emb_mem_model u_mem (.core_clk(core_clk), .pins(pins), .bus(bus));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // issue one request, return cycles from acceptance to answer
  task automatic run(input emb_pkg::emb_kind_t k, input logic [15:0] a,
                     input logic [7:0] w, output int lat);
    lat = 0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req <= '{k, a, w};
    #1;
    while (cycle_start !== 1'b1 && lat < 40) begin
      @(posedge core_clk);
      #1;
      lat++;
    end
    // a request never taken counts as a mismatch
    if (lat >= 40) begin
      n_errors++;
    end
    @(posedge core_clk);
    req_valid <= 1'b0;
    #1;
    lat = 0;
    while (rsp_valid !== 1'b1 && lat < 16) begin
      @(posedge core_clk);
      #1;
      lat++;
    end
  endtask
  // two fetches back to back, then port sample and update values
  task automatic t_fetch;
    int lat;
    run(emb_pkg::EMB_FETCH, 16'h12c3, 8'h00, lat);
    chk(16'(lat), 16'(emb_pkg::FETCH_CAPT) + 16'h1);
    chk(rsp_data, 8'h3c);
    run(emb_pkg::EMB_FETCH, 16'h12c4, 8'h00, lat);
    chk(rsp_data, 8'h3b);
    chk(gp_port_in_q, 8'h3c);
    chk(gp_port_out, 8'h96);
  endtask
  // write then read back two patterns
  task automatic t_wr_rd;
    int lat;
    for (int i = 0; i < 2; i++) begin
      run(emb_pkg::EMB_WRITE, 16'h3456 + 16'(i), 8'ha5 ^ 8'(i * 255), lat);
      run(emb_pkg::EMB_READ, 16'h3456 + 16'(i), 8'h00, lat);
      chk(16'(lat), 16'(emb_pkg::READ_CAPT) + 16'h1);
      chk(rsp_data, 8'ha5 ^ 8'(i * 255));
    end
  endtask
  // flash mode entered only with all straps high
  task automatic t_flash;
    int n_hi;
    @(posedge core_clk);
    strap <= 3'h7;
    flash_req <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    chk(flash_grant, 1'b1);
    chk(req_ready, 1'b0);
    // programmer holds the pulse for its nominal width; grant must stay up
    n_hi = 0;
    repeat (PULSE_CYCLES) begin
      @(posedge core_clk);
      #1;
      n_hi += int'(flash_grant === 1'b1);
    end
    chk(16'(n_hi), 16'(PULSE_CYCLES));
    @(posedge core_clk);
    strap <= 3'h3;
    flash_req <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    chk(flash_mode, 1'b0);
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk(pins.low_addr_data_port_oe, 1'b0);
    t_fetch;
    t_wr_rd;
    t_flash;
    wrap_up;
  end
  // watchdog
  initial begin
    #(25 * 14000);
    n_errors++;
    wrap_up;
  end
endmodule
